// >>> rtl/wdi_pkg.sv
package wdi_pkg;
  // ----------------------------------------------------------------
  // counter geometry and timing
  // ----------------------------------------------------------------
  localparam int          CNT_W      = 15;
  localparam logic [14:0] CNT_START  = 15'h0000;
  localparam logic [14:0] CNT_LAST   = 15'h7fff;
  localparam int          PRESCALE   = 24;
  localparam int          ARM_WINDOW = 1;
  // ----------------------------------------------------------------
  // control register bit positions
  // ----------------------------------------------------------------
  localparam int          TRIG_POS   = 0;
  localparam int          ARM_POS    = 1;
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  typedef enum logic [1:0] {WR_NONE, WR_BIT, WR_BYTE} wdi_wr_t;
endpackage

// >>> rtl/wdi_prescale.sv
module wdi_prescale #(
  parameter int DIV = wdi_pkg::PRESCALE
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic clear,
  output logic      tick
);
  logic [$clog2(DIV)-1:0] cnt;
  wire                    at_end = (cnt == ($clog2(DIV))'(DIV - 1));

  always_ff @(posedge clk) begin
    if (sys_rst || clear || at_end) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick <= 1'b0;
    end else begin
      tick <= at_end && !clear;
    end
  end
endmodule // wdi_prescale

// >>> rtl/wdi_watchdog.sv
// Notes on behaviour
// R1: counter keeps counting in idle mode
// R2: idle overflow raises no reset
// R3: idle overflow restarts the count
// R4: refresh needs arm set, then trigger
// R5: whole-byte writes do not refresh
// R6: no refresh: overflow resets the device
// R7: firmware uses single-bit sets to refresh
// R8: firmware refreshes right after idle exit
// R9: firmware may refresh in timer handler
// R10: refresh clears counter to start
module wdi_watchdog #(
  parameter int CNT_W = wdi_pkg::CNT_W,
  parameter int DIV   = wdi_pkg::PRESCALE
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             wd_enable,
  input  wire logic             idle_mode,
  input  wire wdi_pkg::wdi_wr_t wr_kind,
  input  wire logic [2:0]       wr_bit_sel,
  input  wire logic             wr_bit_val,
  input  wire logic [7:0]       wr_byte,
  output logic [7:0]            watchdog_control_reg,
  output logic [CNT_W-1:0]      wd_count,
  output logic                  wd_reset,
  output logic                  wd_refreshed
);
  // ----------------------------------------------------------------
  // control register writes
  // ----------------------------------------------------------------
  logic tick;
  logic arm_recent;
  wire  bit_wr   = (wr_kind == wdi_pkg::WR_BIT);
  wire  byte_wr  = (wr_kind == wdi_pkg::WR_BYTE);
  wire  arm_set  = bit_wr && wr_bit_val &&
                   (wr_bit_sel == 3'(wdi_pkg::ARM_POS));
  wire  trig_set = bit_wr && wr_bit_val &&
                   (wr_bit_sel == 3'(wdi_pkg::TRIG_POS));
  // R4: arm then trigger
  // R5: byte writes excluded
  wire  refresh  = trig_set && arm_recent &&
                   watchdog_control_reg[wdi_pkg::ARM_POS];
  wire  at_last  = (wd_count == CNT_W'(wdi_pkg::CNT_LAST));
  wire  overflow = wd_enable && tick && at_last && !refresh;
  logic [7:0] next_ctrl;

  always_comb begin
    next_ctrl = watchdog_control_reg;
    if (byte_wr) begin
      next_ctrl = wr_byte;
    end else if (bit_wr) begin
      next_ctrl[wr_bit_sel] = wr_bit_val;
    end
    if (refresh) begin
      next_ctrl[wdi_pkg::ARM_POS]  = 1'b0;
      next_ctrl[wdi_pkg::TRIG_POS] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      watchdog_control_reg <= wdi_pkg::CTRL_RESET;
      arm_recent           <= 1'b0;
    end else begin
      watchdog_control_reg <= next_ctrl;
      // R4: only the very next write may trigger
      if (wr_kind != wdi_pkg::WR_NONE) begin
        arm_recent <= arm_set;
      end
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  wdi_prescale #(.DIV(DIV)) u_pre (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clear   (refresh),
    .tick    (tick)
  );

  always_ff @(posedge clk) begin
    if (sys_rst || !wd_enable) begin
      wd_count <= CNT_W'(wdi_pkg::CNT_START);
    // R10: refresh clears count
    end else if (refresh) begin
      wd_count <= CNT_W'(wdi_pkg::CNT_START);
    // R1: idle does not stop counting
    // R3: overflow wraps to start
    end else if (tick) begin
      wd_count <= wd_count + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wd_reset     <= 1'b0;
      wd_refreshed <= 1'b0;
    end else begin
      // R2: idle suppresses reset
      // R6: overflow resets device
      wd_reset     <= overflow && !idle_mode;
      wd_refreshed <= refresh;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_idle_count;
    @(posedge clk) disable iff (sys_rst)
      wd_enable && idle_mode && tick && !refresh && !at_last
      |=> wd_count == $past(wd_count) + 1'b1;
  endproperty
  a_idle_count: assert property (p_idle_count) // R1
    else $error("counter stalled in idle");

  property p_idle_noreset;
    @(posedge clk) disable iff (sys_rst)
      overflow && idle_mode |=> !wd_reset;
  endproperty
  a_idle_noreset: assert property (p_idle_noreset) // R2
    else $error("reset raised in idle");

  property p_wrap;
    @(posedge clk) disable iff (sys_rst)
      overflow && !refresh |=> wd_count == '0;
  endproperty
  a_wrap: assert property (p_wrap) // R3
    else $error("count did not restart after overflow");

  property p_seq;
    @(posedge clk) disable iff (sys_rst)
      wd_refreshed |-> $past(trig_set);
  endproperty
  a_seq: assert property (p_seq) // R4
    else $error("refresh without trigger set");

  property p_byte;
    @(posedge clk) disable iff (sys_rst)
      byte_wr |=> !wd_refreshed;
  endproperty
  a_byte: assert property (p_byte) // R5
    else $error("byte write refreshed watchdog");

  property p_reset;
    @(posedge clk) disable iff (sys_rst)
      overflow && !idle_mode |=> wd_reset;
  endproperty
  a_reset: assert property (p_reset) // R6
    else $error("overflow gave no reset");

  property p_clear;
    @(posedge clk) disable iff (sys_rst)
      refresh && wd_enable |=> wd_count == '0 ##1 wd_count == '0;
  endproperty
  a_clear: assert property (p_clear) // R10
    else $error("refresh did not clear count");

  property p_pulse;
    @(posedge clk) disable iff (sys_rst)
      wd_reset |-> $past(at_last);
  endproperty
  a_pulse: assert property (p_pulse) // R6
    else $error("reset without terminal count");

  property p_stale;
    @(posedge clk) disable iff (sys_rst)
      trig_set && !arm_recent |=> !wd_refreshed;
  endproperty
  a_stale: assert property (p_stale) // R4
    else $error("trigger without fresh arm refreshed");

  property p_ctrl_clear;
    @(posedge clk) disable iff (sys_rst)
      refresh |=> !watchdog_control_reg[wdi_pkg::ARM_POS] &&
                  !watchdog_control_reg[wdi_pkg::TRIG_POS];
  endproperty
  a_ctrl_clear: assert property (p_ctrl_clear) // R4
    else $error("refresh left arm or trigger set");

  property p_hold;
    @(posedge clk) disable iff (sys_rst)
      wd_enable && !tick && !refresh |=> $stable(wd_count);
  endproperty
  a_hold: assert property (p_hold) // R6
    else $error("count moved without a tick");

  property p_disable;
    @(posedge clk) disable iff (sys_rst)
      !wd_enable |=> wd_count == CNT_W'(wdi_pkg::CNT_START);
  endproperty
  a_disable: assert property (p_disable) // R6
    else $error("count not held while disabled");

  property p_idle_restart;
    @(posedge clk) disable iff (sys_rst)
      overflow && idle_mode |=> wd_count == CNT_W'(wdi_pkg::CNT_START);
  endproperty
  a_idle_restart: assert property (p_idle_restart) // R3
    else $error("idle overflow did not restart count");

  property p_reset_pulse;
    @(posedge clk) disable iff (sys_rst)
      wd_reset |=> !wd_reset;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) // R6
    else $error("reset pulse longer than one cycle");

  property p_refresh_pulse;
    @(posedge clk) disable iff (sys_rst)
      wd_refreshed |=> !wd_refreshed;
  endproperty
  a_refresh_pulse: assert property (p_refresh_pulse) // R10
    else $error("refresh pulse longer than one cycle");

  // ----------------------------------------------------------------
  // cover points
  // ----------------------------------------------------------------

  c_refresh: cover property (@(posedge clk) disable iff (sys_rst)
    arm_set ##1 trig_set);
  c_idle_ovf: cover property (@(posedge clk) disable iff (sys_rst)
    overflow && idle_mode);
  c_reset: cover property (@(posedge clk) disable iff (sys_rst)
    wd_reset);
  c_stale: cover property (@(posedge clk) disable iff (sys_rst)
    trig_set && !arm_recent);
  c_idle_exit: cover property (@(posedge clk) disable iff (sys_rst)
    $fell(idle_mode) ##[1:8] refresh);
endmodule // wdi_watchdog

// >>> tb/watchdog_idle_refresh_tb.sv
module watchdog_idle_refresh_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic             clk = 1'b0;
  logic             sys_rst = 1'b1;
  logic             idle_mode = 1'b0;
  logic             wd_enable = 1'b1;
  wdi_pkg::wdi_wr_t wr_kind;
  logic [2:0]       wr_bit_sel;
  logic             wr_bit_val;
  logic [7:0]       wr_byte;
  logic [7:0]       ctrl;
  logic [3:0]       cnt;
  logic             wd_reset;
  logic             wd_refreshed;
  int               n_mismatch = 0;
  int               total_checks = 0;
  int               rs;
  int               wr;
  always #2.5 clk = ~clk;
  wdi_cpu_model i_cpu (.clk(clk), .wr_kind(wr_kind), .wr_bit_sel(wr_bit_sel),
    .wr_bit_val(wr_bit_val), .wr_byte(wr_byte));
  wdi_watchdog #(.CNT_W(4), .DIV(2)) i_dut (.clk(clk), .sys_rst(sys_rst),
    .wd_enable(wd_enable), .idle_mode(idle_mode), .wr_kind(wr_kind),
    .wr_bit_sel(wr_bit_sel), .wr_bit_val(wr_bit_val), .wr_byte(wr_byte),
    .watchdog_control_reg(ctrl), .wd_count(cnt), .wd_reset(wd_reset),
    .wd_refreshed(wd_refreshed));
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // bounded run counting reset pulses and counter wraps
  task automatic run(input int n, output int r, output int w);
    logic [3:0] p;
    r = 0;
    w = 0;
    repeat (n) begin
      p = cnt;
      @(posedge clk);
      #1;
      if (wd_reset === 1'b1) r++;
      if (p === 4'hf && cnt === 4'h0) w++;
    end
  endtask
  task automatic t_refresh;
    i_cpu.refresh();
    #1;
    chk({7'h0, wd_refreshed}, 8'h01, "no refresh pulse");
    chk({4'h0, cnt}, 8'h00, "count not cleared");
    chk(ctrl, 8'h00, "arm and trigger not cleared");
    @(posedge clk);
    #1;
    chk({7'h0, wd_refreshed}, 8'h00, "pulse too long");
    i_cpu.refresh_fast();
    #1;
    chk({7'h0, wd_refreshed}, 8'h01, "back to back refresh lost");
    chk({4'h0, cnt}, 8'h00, "count not cleared again");
    i_cpu.set_bit(3'(wdi_pkg::ARM_POS));
    i_cpu.set_bit(3'h4);
    i_cpu.set_bit(3'(wdi_pkg::TRIG_POS));
    #1;
    chk({7'h0, wd_refreshed}, 8'h00, "stale arm refreshed");
    chk(ctrl, 8'h13, "bit writes lost");
    $display("refresh test done");
  endtask
  task automatic t_bytes;
    i_cpu.refresh();
    i_cpu.wr_full(8'h02);
    i_cpu.wr_full(8'h01);
    #1;
    chk({7'h0, wd_refreshed}, 8'h00, "byte writes refreshed");
    chk(ctrl, 8'h01, "byte write lost");
    run(40, rs, wr);
    chk(rs[7:0], 8'h01, "overflow reset count");
    $display("byte write test done");
  endtask
  task automatic t_idle;
    i_cpu.refresh();
    @(posedge clk) idle_mode <= 1'b1;
    #1;
    run(40, rs, wr);
    chk(rs[7:0], 8'h00, "reset in idle");
    chk(wr[7:0], 8'h01, "no wrap in idle");
    @(posedge clk) idle_mode <= 1'b0;
    i_cpu.refresh();
    #1;
    chk({7'h0, wd_refreshed}, 8'h01, "exit refresh lost");
    run(20, rs, wr);
    chk(rs[7:0], 8'h00, "reset after exit");
    $display("idle test done");
  endtask
  task automatic t_reset_vals;
    chk(ctrl, 8'h00, "ctrl reset value");
    chk({2'h0, wd_refreshed, wd_reset, cnt}, 8'h00, "outputs after reset");
    $display("reset test done");
  endtask
  task automatic t_disable;
    @(posedge clk) wd_enable <= 1'b0;
    #1;
    run(40, rs, wr);
    chk({4'h0, cnt}, 8'h00, "count not held while disabled");
    chk(rs[7:0], 8'h00, "reset while disabled");
    @(posedge clk) wd_enable <= 1'b1;
    #1;
    $display("disable test done");
  endtask
  task automatic t_timer;
    i_cpu.refresh();
    @(posedge clk) idle_mode <= 1'b1;
    #1;
    run(20, rs, wr);
    chk(rs[7:0], 8'h00, "reset before timer exit");
    chk(wr[7:0], 8'h00, "wrap before timer exit");
    @(posedge clk) idle_mode <= 1'b0;
    i_cpu.refresh();
    #1;
    chk({7'h0, wd_refreshed}, 8'h01, "handler refresh lost");
    @(posedge clk) idle_mode <= 1'b1;
    #1;
    run(20, rs, wr);
    chk(wr[7:0], 8'h00, "overflow despite handler refresh");
    @(posedge clk) idle_mode <= 1'b0;
    $display("timer exit test done");
  endtask
  task automatic t_rst_mid;
    i_cpu.set_bit(3'(wdi_pkg::ARM_POS));
    @(posedge clk) sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    t_reset_vals();
    i_cpu.set_bit(3'(wdi_pkg::TRIG_POS));
    #1;
    chk({7'h0, wd_refreshed}, 8'h00, "arm survived reset");
    chk(ctrl, 8'h01, "trigger bit lost");
    $display("mid-run reset test done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    t_reset_vals();
    t_refresh();
    t_bytes();
    t_idle();
    t_disable();
    t_timer();
    t_rst_mid();
    give_verdict();
  end
endmodule // watchdog_idle_refresh_tb

// >>> tb/wdi_cpu_model.sv
module wdi_cpu_model (
  input  wire logic        clk,
  output wdi_pkg::wdi_wr_t wr_kind,
  output logic [2:0]       wr_bit_sel,
  output logic             wr_bit_val,
  output logic [7:0]       wr_byte
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    wr_kind = wdi_pkg::WR_NONE;
    wr_bit_sel = 3'h0;
    wr_bit_val = 1'b0;
    wr_byte = 8'h00;
  end
  task automatic set_bit(input logic [2:0] s);
    @(posedge clk);
    wr_kind <= wdi_pkg::WR_BIT;
    wr_bit_sel <= s;
    wr_bit_val <= 1'b1;
    @(posedge clk);
    wr_kind <= wdi_pkg::WR_NONE;
    wr_bit_val <= 1'b0;
  endtask
  task automatic wr_full(input logic [7:0] d);
    @(posedge clk);
    wr_kind <= wdi_pkg::WR_BYTE;
    wr_byte <= d;
    @(posedge clk);
    wr_kind <= wdi_pkg::WR_NONE;
    wr_byte <= ~d;
  endtask
  task automatic refresh;
    set_bit(3'h1);
    set_bit(3'h0);
  endtask
  // arm and trigger back to back
  task automatic refresh_fast;
    @(posedge clk);
    wr_kind <= wdi_pkg::WR_BIT;
    wr_bit_sel <= 3'h1;
    wr_bit_val <= 1'b1;
    @(posedge clk);
    wr_bit_sel <= 3'h0;
    @(posedge clk);
    wr_kind <= wdi_pkg::WR_NONE;
    wr_bit_val <= 1'b0;
  endtask
endmodule // wdi_cpu_model
